// file: tlca_regs.vh
// constants for the temperature limit compare and alert block
// assumes: included by bare name from design, checker and bench files
`ifndef TLCA_REGS_VH
`define TLCA_REGS_VH

// ----------------------------------------------------------------
// register pointers (4-bit register address)
// ----------------------------------------------------------------
`define TLCA_PTR_CAP        4'h0
`define TLCA_PTR_CFG        4'h1
`define TLCA_PTR_HIGH       4'h2
`define TLCA_PTR_LOW        4'h3
`define TLCA_PTR_CRIT       4'h4
`define TLCA_PTR_TEMP       4'h5
`define TLCA_PTR_PIN        4'h6

// ----------------------------------------------------------------
// configuration register bit positions
// ----------------------------------------------------------------
`define TLCA_CFG_MODE       0
`define TLCA_CFG_POL        1
`define TLCA_CFG_CRIT_ONLY  2
`define TLCA_CFG_OUT_EN     3
`define TLCA_CFG_EVT_STS    4
`define TLCA_CFG_CLEAR      5
`define TLCA_CFG_ALM_LOCK   6
`define TLCA_CFG_CRIT_LOCK  7
`define TLCA_CFG_SENSOR_SHUTDOWN       8
`define TLCA_CFG_HYSTERESIS_SELECT_LO    9
`define TLCA_CFG_HYSTERESIS_SELECT_HI    10

// ----------------------------------------------------------------
// reading register flag positions and field layout
// ----------------------------------------------------------------
`define TLCA_TEMP_CRIT_BIT  15
`define TLCA_TEMP_HIGH_BIT  14
`define TLCA_TEMP_LOW_BIT   13
`define TLCA_SIGN_BIT       12
`define TLCA_LIM_LSB        2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TLCA_LIMIT_RST      16'h0000
`define TLCA_TEMP_RST       13'h0000
`define TLCA_HYSTERESIS_SELECT_RST       2'h0
`define TLCA_RES_RST        2'h3

// ----------------------------------------------------------------
// hysteresis offsets in reading lsbs of 0.0625 degree
// ----------------------------------------------------------------
`define TLCA_HYSTERESIS_SELECT_0C0       14'h0000
`define TLCA_HYSTERESIS_SELECT_1C5       14'h0018
`define TLCA_HYSTERESIS_SELECT_3C0       14'h0030
`define TLCA_HYSTERESIS_SELECT_6C0       14'h0060

// ----------------------------------------------------------------
// zone comparator kinds
// ----------------------------------------------------------------
`define TLCA_ZONE_ABOVE     2'h0
`define TLCA_ZONE_BELOW     2'h1
`define TLCA_ZONE_AT_ABOVE  2'h2

`endif

// file: tlca_zone.v
// one limit comparator with a hysteresis-held zone flag
// assumes: reading and limit are 13-bit two's complement, same lsb
`timescale 1ns/1ps
`default_nettype none
`include "tlca_regs.vh"

module tlca_zone #(
  parameter [1:0] KIND = `TLCA_ZONE_ABOVE      // trip direction
) (
  input  wire        i_clk,                    // system clock
  input  wire        i_sys_rst,                // async reset, high
  input  wire        i_eval,                   // update the held zone
  input  wire [12:0] i_temp,                   // recorded reading
  input  wire [12:0] i_limit,                  // aligned limit
  input  wire [13:0] i_hysteresis_select,                   // hysteresis offset
  output reg         o_flag,                   // plain compare, no hysteresis_select
  output reg         o_zone_q                  // held zone with hysteresis_select
);

  // ----------------------------------------------------------------
  // signed compare against the limit and the hysteresis point
  // ----------------------------------------------------------------
  wire signed [13:0] temp_s  = {i_temp[12], i_temp};      // sign extend
  wire signed [13:0] lim_s   = {i_limit[12], i_limit};
  wire signed [13:0] rel_dn  = lim_s - $signed(i_hysteresis_select);   // release below
  wire signed [13:0] rel_up  = lim_s + $signed(i_hysteresis_select);   // release above
  reg                release_c;                           // leave zone
  reg                zone_d;

  // trip and release terms per comparator kind
  always @* begin
    case (KIND)
      `TLCA_ZONE_BELOW: begin
        o_flag    = temp_s < lim_s;
        release_c = temp_s >= rel_up;
      end
      `TLCA_ZONE_AT_ABOVE: begin
        o_flag    = temp_s >= lim_s;
        release_c = temp_s < rel_dn;
      end
      default: begin
        o_flag    = temp_s > lim_s;
        release_c = temp_s <= rel_dn;
      end
    endcase
    zone_d = o_zone_q ? ~release_c : o_flag;
  end

  // held zone, updated only while evaluation runs
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_zone_q <= 1'b0;
    end else if (i_eval) begin
      o_zone_q <= zone_d;
    end
  end

endmodule
`default_nettype wire

// file: tlca_core.v
// temperature reading, trip limits, limit flags and alert pin logic
// assumes: register port driven by a serial bus front end on i_clk,
// conversion results arrive on i_clk, alert pin is open drain
`timescale 1ns/1ps
`default_nettype none
`include "tlca_regs.vh"

module tlca_core #(
  parameter [1:0] RESOLUTION = `TLCA_RES_RST       // resolution capability
) (
  input  wire        i_clk,                        // 100 MHz system clock
  input  wire        i_sys_rst,                    // async reset, high
  input  wire [3:0]  i_reg_addr,                   // register pointer
  input  wire        i_reg_wr,                     // write strobe, pulse
  input  wire [15:0] i_reg_wdata,                  // write data
  input  wire        i_reg_rd,                     // read strobe, pulse
  input  wire        i_sample_valid,               // new conversion, pulse
  input  wire [12:0] i_sample_data,                // conversion result
  input  wire        i_alert_in,                   // alert wire level
  output reg  [15:0] o_reg_rdata_q,                // read data
  output reg         o_reg_rvalid_q,               // read data valid
  output reg         o_alert_out_q,                // alert drive level
  output reg         o_alert_oe_q,                 // alert drive enable
  output reg         o_sensor_run_q                // converter enable
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg  [15:0] high_alarm_limit_q;                  // high limit
  reg  [15:0] low_alarm_limit_q;                   // low limit
  reg  [15:0] critical_limit_q;                    // critical limit
  reg  [12:0] temperature_reading_q;               // recorded reading
  reg         mode_int_q;                          // 1 = interrupt mode
  reg         alert_polarity_q;                    // 1 = active high
  reg         critical_only_select_q;              // critical only
  reg         out_en_q;                            // alert output enable
  reg         alarm_lock_q;                        // alarm limits locked
  reg         crit_lock_q;                         // critical locked
  reg         sensor_shutdown_q;                   // sensor stopped
  reg  [1:0]  hysteresis_select_q;                 // hysteresis code
  reg         evt_latch_q;                         // interrupt latch
  reg         evt_q;                               // internal event level
  reg         pin_meta_q;                          // pin sync stage 1
  reg         pin_sync_q;                          // pin sync stage 2

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // mask of reading bits kept at a given resolution
  function [12:0] res_mask;
    input [1:0] res;
    begin
      case (res)
        2'h0:    res_mask = 13'h1ff8;            // 0.5 degree
        2'h1:    res_mask = 13'h1ffc;            // 0.25 degree
        2'h2:    res_mask = 13'h1ffe;            // 0.125 degree
        default: res_mask = 13'h1fff;            // 0.0625 degree
      endcase
    end
  endfunction

  // align a limit register to the reading lsb, trailing bits zero
  function [12:0] lim_align;
    input [15:0] lim;
    begin
      lim_align = {lim[12:2], 2'b00};
    end
  endfunction

  // keep only the writable limit bits
  function [15:0] lim_clean;
    input [15:0] wd;
    begin
      lim_clean = {3'b000, wd[12:2], 2'b00};
    end
  endfunction

  // hysteresis code to offset in reading lsbs
  function [13:0] hysteresis_select_val;
    input [1:0] code;
    begin
      case (code)
        2'h1:    hysteresis_select_val = `TLCA_HYSTERESIS_SELECT_1C5;
        2'h2:    hysteresis_select_val = `TLCA_HYSTERESIS_SELECT_3C0;
        2'h3:    hysteresis_select_val = `TLCA_HYSTERESIS_SELECT_6C0;
        default: hysteresis_select_val = `TLCA_HYSTERESIS_SELECT_0C0;
      endcase
    end
  endfunction

  wire        any_lock = alarm_lock_q | crit_lock_q;
  wire        wr_cfg   = i_reg_wr & (i_reg_addr == `TLCA_PTR_CFG);
  wire        wr_high  = i_reg_wr & (i_reg_addr == `TLCA_PTR_HIGH);
  wire        wr_low   = i_reg_wr & (i_reg_addr == `TLCA_PTR_LOW);
  wire        wr_crit  = i_reg_wr & (i_reg_addr == `TLCA_PTR_CRIT);
  wire        clr_req  = wr_cfg & i_reg_wdata[`TLCA_CFG_CLEAR];
  wire [13:0] hysteresis_select_off = hysteresis_select_val(hysteresis_select_q);

  // ----------------------------------------------------------------
  // alert pin level synchroniser
  // ----------------------------------------------------------------
  // two stages before the wire level is read back
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= i_alert_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // limit registers
  // ----------------------------------------------------------------
  // alarm limits follow the alarm lock, critical its own lock
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      high_alarm_limit_q <= `TLCA_LIMIT_RST;
      low_alarm_limit_q  <= `TLCA_LIMIT_RST;
      critical_limit_q   <= `TLCA_LIMIT_RST;
    end else begin
      if (wr_high & ~alarm_lock_q) begin
        high_alarm_limit_q <= lim_clean(i_reg_wdata);
      end
      if (wr_low & ~alarm_lock_q) begin
        low_alarm_limit_q <= lim_clean(i_reg_wdata);
      end
      if (wr_crit & ~crit_lock_q) begin
        critical_limit_q <= lim_clean(i_reg_wdata);
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // locks set only, released by reset alone; mode, polarity, output enable and hysteresis frozen by either lock
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_int_q             <= 1'b0;
      alert_polarity_q       <= 1'b0;
      critical_only_select_q <= 1'b0;
      out_en_q               <= 1'b0;
      alarm_lock_q           <= 1'b0;
      crit_lock_q            <= 1'b0;
      sensor_shutdown_q      <= 1'b0;
      hysteresis_select_q    <= `TLCA_HYSTERESIS_SELECT_RST;
    end else if (wr_cfg) begin
      if (~any_lock) begin
        mode_int_q          <= i_reg_wdata[`TLCA_CFG_MODE];
        alert_polarity_q    <= i_reg_wdata[`TLCA_CFG_POL];
        out_en_q            <= i_reg_wdata[`TLCA_CFG_OUT_EN];
        hysteresis_select_q <= i_reg_wdata[`TLCA_CFG_HYSTERESIS_SELECT_HI:`TLCA_CFG_HYSTERESIS_SELECT_LO];
      end
      // critical-only may be cleared always, set only while the alarm lock is clear
      if (~alarm_lock_q | ~i_reg_wdata[`TLCA_CFG_CRIT_ONLY]) begin
        critical_only_select_q <= i_reg_wdata[`TLCA_CFG_CRIT_ONLY];
      end
      // shutdown may be cleared always, set only when unlocked
      if (~any_lock | ~i_reg_wdata[`TLCA_CFG_SENSOR_SHUTDOWN]) begin
        sensor_shutdown_q <= i_reg_wdata[`TLCA_CFG_SENSOR_SHUTDOWN];
      end
      if (i_reg_wdata[`TLCA_CFG_ALM_LOCK]) begin
        alarm_lock_q <= 1'b1;
      end
      if (i_reg_wdata[`TLCA_CFG_CRIT_LOCK]) begin
        crit_lock_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // temperature reading
  // ----------------------------------------------------------------
  // record each conversion unless shut down; drop unsupported bits
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      temperature_reading_q <= `TLCA_TEMP_RST;
    end else if (i_sample_valid & ~sensor_shutdown_q) begin
      temperature_reading_q <= i_sample_data & res_mask(RESOLUTION);
    end
  end

  // converter runs while not shut down
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sensor_run_q <= 1'b0;
    end else begin
      o_sensor_run_q <= ~sensor_shutdown_q;
    end
  end

  // ----------------------------------------------------------------
  // limit comparators
  // ----------------------------------------------------------------
  // index 0 high, 1 low, 2 critical
  wire [38:0] lim_bus  = {lim_align(critical_limit_q),
                          lim_align(low_alarm_limit_q),
                          lim_align(high_alarm_limit_q)};
  localparam [5:0] KIND_BUS = {`TLCA_ZONE_AT_ABOVE, `TLCA_ZONE_BELOW, `TLCA_ZONE_ABOVE};
  wire [2:0]  flag_c;                          // plain compare results
  wire [2:0]  zone_q;                          // hysteresis zones
  wire        eval_en  = ~sensor_shutdown_q;   // re-evaluate every cycle unless shut down

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
      // every cycle unless shut down, so a new reading or limit is seen at once
      tlca_zone #(
        .KIND     (KIND_BUS[2*gi+1:2*gi])
      ) u_zone (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_eval   (eval_en),
        .i_temp   (temperature_reading_q),
        .i_limit  (lim_bus[13*gi+12:13*gi]),
        .i_hysteresis_select   (hysteresis_select_off),
        .o_flag   (flag_c[gi]),
        .o_zone_q (zone_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // event logic
  // ----------------------------------------------------------------
  reg  [1:0] alarm_prev_q;                     // alarm zones last cycle
  wire       alarm_cross = |(alarm_prev_q ^ zone_q[1:0]) & ~critical_only_select_q;
  wire       crit_hold   = zone_q[2];
  reg        latch_d;
  reg        evt_d;

  // next interrupt latch and event level
  always @* begin
    latch_d = evt_latch_q;
    if (clr_req & mode_int_q & ~crit_hold) begin
      latch_d = 1'b0;
    end
    if (mode_int_q & alarm_cross & eval_en) begin
      latch_d = 1'b1;                          // set wins
    end
    if (~mode_int_q) begin
      latch_d = 1'b0;                          // clear ignored
    end
    if (sensor_shutdown_q) begin
      // frozen, but a clear may still release it
      if (clr_req & mode_int_q) begin
        evt_d = 1'b0;
      end else begin
        evt_d = evt_q;
      end
    end else if (mode_int_q) begin
      evt_d = latch_d | crit_hold;
    end else if (critical_only_select_q) begin
      evt_d = crit_hold;
    end else begin
      evt_d = |zone_q;
    end
  end

  // latch, event level and previous alarm zones
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      evt_latch_q  <= 1'b0;
      evt_q        <= 1'b0;
      alarm_prev_q <= 2'b00;
    end else begin
      evt_latch_q  <= sensor_shutdown_q ? (evt_latch_q & ~(clr_req & mode_int_q))
                                        : latch_d;
      evt_q        <= evt_d;
      alarm_prev_q <= eval_en ? zone_q[1:0] : alarm_prev_q;
    end
  end

  // ----------------------------------------------------------------
  // alert pin drive
  // ----------------------------------------------------------------
  // open drain: only pulls low; disabled leaves idle level by polarity
  wire evt_sts = evt_q & out_en_q;             // software copy of pin
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_alert_out_q <= 1'b0;
      o_alert_oe_q  <= 1'b0;
    end else begin
      o_alert_out_q <= 1'b0;
      if (out_en_q) begin
        o_alert_oe_q <= alert_polarity_q ? ~evt_q : evt_q;
      end else begin
        o_alert_oe_q <= alert_polarity_q;      // grounded when high-true
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  reg [15:0] rd_mux;

  // read data selection; unmapped pointers read zero
  always @* begin
    case (i_reg_addr)
      `TLCA_PTR_CAP: begin
        rd_mux = {8'h00, 3'b000, RESOLUTION, 3'b101};
      end
      `TLCA_PTR_CFG: begin
        rd_mux = {5'h00, hysteresis_select_q, sensor_shutdown_q,
                  crit_lock_q, alarm_lock_q, 1'b0, evt_sts,
                  out_en_q, critical_only_select_q, alert_polarity_q,
                  mode_int_q};
      end
      `TLCA_PTR_HIGH: begin
        rd_mux = high_alarm_limit_q;
      end
      `TLCA_PTR_LOW: begin
        rd_mux = low_alarm_limit_q;
      end
      `TLCA_PTR_CRIT: begin
        rd_mux = critical_limit_q;
      end
      `TLCA_PTR_TEMP: begin
        // flags from plain compares; sign in bit 12
        rd_mux = {flag_c[2], flag_c[0], flag_c[1],
                  temperature_reading_q};
      end
      `TLCA_PTR_PIN: begin
        rd_mux = {15'h0000, pin_sync_q};
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  // read answer one cycle after the strobe
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata_q  <= 16'h0000;
      o_reg_rvalid_q <= 1'b0;
    end else begin
      o_reg_rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata_q <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// file: tlca_alert_line.sv
// open-drain alert wire with its pull-up, as seen by the host
// assumes: every driver only pulls the wire low
`timescale 1ns/1ps
`default_nettype none

module tlca_alert_line (
  input  wire logic i_drive_en,   // some party pulls low
  output wire logic o_level       // resolved wire level
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // released wire floats up through the pull-up, never left at x
  assign o_level = i_drive_en ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// file: tlca_core_chk.sv
// port checker for the limit compare and alert core
// assumes: bound to tlca_core, one clock, async reset high
`timescale 1ns/1ps
`default_nettype none
`include "tlca_regs.vh"

module tlca_core_chk #(
  parameter [1:0] RESOLUTION = 2'h3   // resolution capability
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [3:0]  i_reg_addr,
  input wire logic        i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_rd,
  input wire logic        i_sample_valid,
  input wire logic [12:0] i_sample_data,
  input wire logic        i_alert_in,
  input wire logic [15:0] o_reg_rdata_q,
  input wire logic        o_reg_rvalid_q,
  input wire logic        o_alert_out_q,
  input wire logic        o_alert_oe_q,
  input wire logic        o_sensor_run_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  chk_rd_answer: assert property (
    o_reg_rvalid_q == $past(i_reg_rd)) else $error("read answer out of step");
  chk_rdata_hold: assert property (
    !o_reg_rvalid_q |-> $stable(o_reg_rdata_q)) else $error("read data moved");
  chk_lim_zero_bits: assert property (
    i_reg_rd && i_reg_addr >= `TLCA_PTR_HIGH && i_reg_addr <= `TLCA_PTR_CRIT
    |=> o_reg_rdata_q[15:13] == 3'h0 && o_reg_rdata_q[1:0] == 2'h0)
    else $error("limit spare bits set");
  chk_temp_mask: assert property (
    i_reg_rd && i_reg_addr == `TLCA_PTR_TEMP
    |=> (o_reg_rdata_q[2:0] & (3'h7 >> RESOLUTION)) == 3'h0)
    else $error("fraction below resolution set");
  chk_cap_value: assert property (
    i_reg_rd && i_reg_addr == `TLCA_PTR_CAP
    |=> o_reg_rdata_q == {11'h000, RESOLUTION, 3'h5}) else $error("capability wrong");
  // ----------------------------------------------------------------
  // alert pin and shutdown
  // ----------------------------------------------------------------
  chk_out_low: assert property (
    o_alert_out_q == 1'b0) else $error("alert drives high");
  chk_run_clear: assert property (
    i_reg_wr && i_reg_addr == `TLCA_PTR_CFG && !i_reg_wdata[`TLCA_CFG_SENSOR_SHUTDOWN]
    |-> ##2 o_sensor_run_q) else $error("wake not taken");
  chk_sensor_shutdown_freeze: assert property (
    (!o_sensor_run_q && !i_reg_wr) [*6] |-> $stable(o_alert_oe_q))
    else $error("alert moved in shutdown");
  // main scenarios
  cov_alert: cover property ($rose(o_alert_oe_q));
  cov_sensor_shutdown: cover property (!o_sensor_run_q);
  cov_read: cover property (o_reg_rvalid_q);
endmodule

`default_nettype wire

// file: tlca_core_tb_top.sv
// bench for the limit compare and alert core: register and sample tasks
// assumes: tlca_core, its checker and the alert wire model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tlca_regs.vh"

module tlca_core_tb_top;
  localparam [1:0] RES = 2'h2;   // 0.125 degree, bit 0 masked
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [3:0]  i_reg_addr = 4'h0;
  logic        i_reg_wr = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_reg_rd = 1'b0;
  logic        i_sample_valid = 1'b0;
  logic [12:0] i_sample_data = 13'h0000;
  wire         alert_wire;   // resolved alert level
  wire  [15:0] o_reg_rdata_q;
  wire         o_reg_rvalid_q, o_alert_out_q, o_alert_oe_q, o_sensor_run_q;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0;

  tlca_core #(.RESOLUTION(RES)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .i_reg_rd(i_reg_rd), .i_sample_valid(i_sample_valid),
    .i_sample_data(i_sample_data), .i_alert_in(alert_wire),
    .o_reg_rdata_q(o_reg_rdata_q), .o_reg_rvalid_q(o_reg_rvalid_q),
    .o_alert_out_q(o_alert_out_q), .o_alert_oe_q(o_alert_oe_q),
    .o_sensor_run_q(o_sensor_run_q));
  tlca_alert_line u_line (.i_drive_en(o_alert_oe_q), .o_level(alert_wire));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // hang guard
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    #1;
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(posedge i_clk);
    #1;
    i_reg_rd = 1'b0;
    chk({15'h0000, o_reg_rvalid_q}, 16'h0001);
    chk(o_reg_rdata_q, exp);
  endtask
  // alert enable four edges after the taking edge
  task automatic look(input logic exp);
    repeat (4) @(posedge i_clk);
    #1;
    chk({15'h0000, o_alert_oe_q}, {15'h0000, exp});
  endtask
  task automatic st(input logic [12:0] v, input logic exp);
    @(posedge i_clk);
    #1;
    i_sample_valid = 1'b1;
    i_sample_data = v;
    @(posedge i_clk);
    #1;
    i_sample_valid = 1'b0;
    look(exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    rd(`TLCA_PTR_CAP, 16'h0015);
    rd(`TLCA_PTR_CFG, 16'h0000);
    rd(`TLCA_PTR_PIN, 16'h0001);
    rd(`TLCA_PTR_TEMP, 16'h8000);
    rd(4'hf, 16'h0000);   // unmapped place
    wr(`TLCA_PTR_HIGH, 16'hffff);
    rd(`TLCA_PTR_HIGH, 16'h1ffc);
    wr(`TLCA_PTR_HIGH, 16'h0320);
    wr(`TLCA_PTR_LOW, 16'h0190);
    wr(`TLCA_PTR_CRIT, 16'h07d0);
    wr(`TLCA_PTR_CFG, 16'h0008);
    st(13'h0200, 1'b0);
    rd(`TLCA_PTR_TEMP, 16'h0200);
    st(13'h0330, 1'b1);
    rd(`TLCA_PTR_TEMP, 16'h4330);
    st(13'h0320, 1'b0);
    rd(`TLCA_PTR_TEMP, 16'h0320);
    st(13'h1e70, 1'b1);
    rd(`TLCA_PTR_TEMP, 16'h3e70);
    st(13'h07d0, 1'b1);
    rd(`TLCA_PTR_TEMP, 16'hc7d0);
    st(13'h0191, 1'b0);
    rd(`TLCA_PTR_TEMP, 16'h0190);
    // 3 degree hysteresis
    wr(`TLCA_PTR_CFG, 16'h0408);
    st(13'h0330, 1'b1);
    st(13'h0310, 1'b1);
    st(13'h02f0, 1'b0);
    wr(`TLCA_PTR_HIGH, 16'h02e0);
    look(1'b1);
    wr(`TLCA_PTR_HIGH, 16'h0400);
    look(1'b0);
    // interrupt mode
    wr(`TLCA_PTR_CFG, 16'h0009);
    wr(`TLCA_PTR_CFG, 16'h0029);
    look(1'b0);
    st(13'h0410, 1'b1);
    st(13'h0200, 1'b1);
    wr(`TLCA_PTR_CFG, 16'h0029);
    look(1'b0);
    rd(`TLCA_PTR_CFG, 16'h0009);
    st(13'h0800, 1'b1);
    wr(`TLCA_PTR_CFG, 16'h0029);
    look(1'b1);
    rd(`TLCA_PTR_CFG, 16'h0019);
    st(13'h0200, 1'b1);
    wr(`TLCA_PTR_CFG, 16'h0029);
    look(1'b0);
    // critical-only comparator
    wr(`TLCA_PTR_CFG, 16'h000c);
    st(13'h0410, 1'b0);
    st(13'h0800, 1'b1);
    st(13'h0200, 1'b0);
    // active high, then disabled
    wr(`TLCA_PTR_CFG, 16'h000a);
    look(1'b1);
    rd(`TLCA_PTR_PIN, 16'h0000);
    wr(`TLCA_PTR_CFG, 16'h0002);
    look(1'b1);
    // shutdown freezes reading and alert
    wr(`TLCA_PTR_CFG, 16'h0008);
    st(13'h0410, 1'b1);
    wr(`TLCA_PTR_CFG, 16'h0108);
    @(posedge i_clk);
    #1;
    chk({15'h0000, o_sensor_run_q}, 16'h0000);
    st(13'h0200, 1'b1);
    rd(`TLCA_PTR_TEMP, 16'h4410);
    wr(`TLCA_PTR_CFG, 16'h0008);
    st(13'h0200, 1'b0);
    // core lets go of the shared wire
    wr(`TLCA_PTR_CFG, 16'h0000);
    look(1'b0);
    // alarm lock refuses alarm limit and config writes until reset; critical limit still written
    wr(`TLCA_PTR_CFG, 16'h0040);
    wr(`TLCA_PTR_HIGH, 16'h0100);
    rd(`TLCA_PTR_HIGH, 16'h0400);
    wr(`TLCA_PTR_CRIT, 16'h0600);
    rd(`TLCA_PTR_CRIT, 16'h0600);
    wr(`TLCA_PTR_CFG, 16'h0105);
    rd(`TLCA_PTR_CFG, 16'h0040);
    // mid-run reset releases the locks
    @(posedge i_clk);
    #1;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    rd(`TLCA_PTR_CFG, 16'h0000);
    rd(`TLCA_PTR_HIGH, 16'h0000);
    print_verdict();
  end
endmodule

bind tlca_core tlca_core_chk #(.RESOLUTION(RESOLUTION)) u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .i_sample_valid(i_sample_valid),
  .i_sample_data(i_sample_data), .i_alert_in(i_alert_in),
  .o_reg_rdata_q(o_reg_rdata_q), .o_reg_rvalid_q(o_reg_rvalid_q),
  .o_alert_out_q(o_alert_out_q), .o_alert_oe_q(o_alert_oe_q),
  .o_sensor_run_q(o_sensor_run_q));

`default_nettype wire
